/* rtl/sadc_pkg.sv */
package sadc_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_CLOCK  = 8'h08;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // ==========================================================================
  // channel codes
  localparam logic [4:0] CHAN_OFF   = 5'h1f;
  localparam logic [4:0] CHAN_HREF  = 5'h1d;
  localparam logic [4:0] CHAN_LREF  = 5'h1e;

  // ==========================================================================
  // sequencer timing: steps per conversion period, two steps per bit
  localparam logic [3:0] STEP_LAST  = 4'hf;
  localparam logic [2:0] BIT_TOP    = 3'h7;

  // prescaler terminal counts for divide by 1, 2, 4, 8, 16
  localparam logic [3:0] LIM_DIV1   = 4'h0;
  localparam logic [3:0] LIM_DIV2   = 4'h1;
  localparam logic [3:0] LIM_DIV4   = 4'h3;
  localparam logic [3:0] LIM_DIV8   = 4'h7;
  localparam logic [3:0] LIM_DIV16  = 4'hf;

  // ==========================================================================
  // register layouts
  typedef struct packed {
    logic       done;
    logic       irq_en;
    logic       cont;
    logic [4:0] chan;
  } sadc_ctrl_t;

  typedef struct packed {
    logic [2:0] prescale;
    logic       source;
    logic [3:0] unused;
  } sadc_clk_t;

  localparam sadc_ctrl_t CTRL_RESET = '{done: 1'b0, irq_en: 1'b0, cont: 1'b0, chan: 5'h1f};
  localparam sadc_clk_t  CLK_RESET  = '{prescale: 3'h0, source: 1'b0, unused: 4'h0};

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_CONVERT = 2'b10
  } sadc_state_t;

endpackage

/* rtl/sadc_top.sv */
`timescale 1ns/10ps

// How it works
// - wait mode changes nothing; conversions and interrupt keep running.
// - stop input aborts any conversion; pending work resumes after stop ends.
// - without irq enable, done flag sets per conversion, clears on result read.
// - with irq enable, done flag never sets and reads zero.
// - with irq enable, interrupt at each end; dropped by result read or status write.
// - continuous bit repeats conversions; clear means one conversion only.
// - five-bit channel field; codes 0 to 14 pick external inputs.
// - all-ones channel code powers the converter off; reset selects it.
// - after power-off one settling conversion period precedes valid results.
// - codes 29 and 30 route high and low references; 27 reserved.
// - unused channel codes give whatever the comparator yields.
// - one 8-bit result register rewritten at each conversion end.
// - 3-bit prescaler divides source by 1, 2, 4, 8 or 16.
// - source bit one picks bus clock, zero crystal; reset picks crystal.
// - each status write of a code other than all-ones starts a conversion lasting 16 to 17 converter clocks.
module sadc_top (
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic        CRYSTAL_CLK_IN,
  input  wire logic        COMPARE_IN,
  input  wire logic        STOP_MODE_IN,
  output logic [4:0]       CHANNEL_SEL_OUT,
  output logic [7:0]       TRIAL_CODE_OUT,
  output logic             POWER_DOWN_OUT,
  output logic             IRQ_OUT
);

  // ==========================================================================
  // declarations
  sadc_pkg::sadc_ctrl_t  ctrl;
  sadc_pkg::sadc_clk_t   clkr;
  sadc_pkg::sadc_state_t state;
  logic [7:0]  result;
  logic [7:0]  trial;
  logic [7:0]  next_trial;
  logic [3:0]  step;
  logic [3:0]  div_cnt;
  logic [2:0]  bit_idx;
  logic        run_req;
  logic        need_settle;
  logic        xtal_s1;
  logic        xtal_s2;
  logic        xtal_s3;
  logic        cmp_s1;
  logic        cmp_s2;
  logic        aw_have;
  logic        w_have;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;
  logic        wr_fire;
  logic        wr_status;
  logic        wr_clock;
  logic        rd_fire;
  logic        rd_result;
  logic        src_en;
  logic        conv_tick;
  logic        conv_end;
  logic        powered;
  logic        halt;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] prescale_limit(input logic [2:0] code);
    logic [3:0] lim;
    lim = sadc_pkg::LIM_DIV16;
    unique case (code)
      3'h0:    lim = sadc_pkg::LIM_DIV1;
      3'h1:    lim = sadc_pkg::LIM_DIV2;
      3'h2:    lim = sadc_pkg::LIM_DIV4;
      3'h3:    lim = sadc_pkg::LIM_DIV8;
      default: lim = sadc_pkg::LIM_DIV16;
    endcase
    return lim;
  endfunction

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      cmp_s1  <= 1'b0;
      cmp_s2  <= 1'b0;
    end
    else
    begin
      xtal_s1 <= CRYSTAL_CLK_IN;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      cmp_s1  <= COMPARE_IN;
      cmp_s2  <= cmp_s1;
    end
  end

  // ==========================================================================
  // axi4-lite write channels
  assign wr_fire   = aw_have & w_have & ~BVALID_OUT;
  assign wr_status = wr_fire & w_lane0 & (aw_addr == sadc_pkg::OFS_STATUS);
  assign wr_clock  = wr_fire & w_lane0 & (aw_addr == sadc_pkg::OFS_CLOCK);

  // address and data are held until both are present
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      aw_have     <= 1'b0;
      aw_addr     <= 8'h00;
      AWREADY_OUT <= 1'b1;
      w_have      <= 1'b0;
      w_data      <= 8'h00;
      w_lane0     <= 1'b0;
      WREADY_OUT  <= 1'b1;
    end
    else
    begin
      if (AWVALID_IN & AWREADY_OUT)
      begin
        aw_have     <= 1'b1;
        aw_addr     <= AWADDR_IN;
        AWREADY_OUT <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_have     <= 1'b0;
        AWREADY_OUT <= 1'b1;
      end
      if (WVALID_IN & WREADY_OUT)
      begin
        w_have     <= 1'b1;
        w_data     <= WDATA_IN[7:0];
        w_lane0    <= WSTRB_IN[0];
        WREADY_OUT <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_have     <= 1'b0;
        WREADY_OUT <= 1'b1;
      end
    end
  end

  // write response, slave error for unmapped or result address
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= sadc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      BVALID_OUT <= 1'b1;
      BRESP_OUT  <= (aw_addr == sadc_pkg::OFS_STATUS || aw_addr == sadc_pkg::OFS_CLOCK)
                    ? sadc_pkg::RESP_OKAY : sadc_pkg::RESP_SLV;
    end
    else if (BREADY_IN)
      BVALID_OUT <= 1'b0;
  end

  // ==========================================================================
  // axi4-lite read channels
  assign rd_fire   = ARVALID_IN & ARREADY_OUT;
  assign rd_result = rd_fire & (ARADDR_IN == sadc_pkg::OFS_RESULT);

  // read data captured at the address handshake
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= sadc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b1;
      RRESP_OUT   <= sadc_pkg::RESP_OKAY;
      unique case (ARADDR_IN)
        sadc_pkg::OFS_STATUS: RDATA_OUT <= {24'h000000, ctrl.done & ~ctrl.irq_en,
                                            ctrl[6:0]};
        sadc_pkg::OFS_RESULT: RDATA_OUT <= {24'h000000, result};
        sadc_pkg::OFS_CLOCK:  RDATA_OUT <= {24'h000000, clkr};
        default:
        begin
          RDATA_OUT <= 32'h0000_0000;
          RRESP_OUT <= sadc_pkg::RESP_SLV;
        end
      endcase
    end
    else if (RVALID_OUT & RREADY_IN)
    begin
      RVALID_OUT  <= 1'b0;
      ARREADY_OUT <= 1'b1;
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      ctrl           <= sadc_pkg::CTRL_RESET;
      clkr           <= sadc_pkg::CLK_RESET;
      POWER_DOWN_OUT <= 1'b1;
    end
    else
    begin
      if (wr_status)
      begin
        ctrl.irq_en    <= w_data[6];
        ctrl.cont      <= w_data[5];
        ctrl.chan      <= w_data[4:0];
        POWER_DOWN_OUT <= (w_data[4:0] == sadc_pkg::CHAN_OFF);
      end
      if (wr_clock)
        clkr <= {w_data[7:4], 4'h0};
      // done flag: end of conversion wins over a result read; a status write suppresses the end and clears
      if (conv_end & ~ctrl.irq_en)
        ctrl.done <= 1'b1;
      else if (rd_result | wr_status | ctrl.irq_en)
        ctrl.done <= 1'b0;
    end
  end

  // interrupt request, live in wait mode too
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      IRQ_OUT <= 1'b0;
    else if (conv_end & ctrl.irq_en)
      IRQ_OUT <= 1'b1;
    else if (rd_result | wr_status)
      IRQ_OUT <= 1'b0;
  end

  // ==========================================================================
  // converter clock: source select then prescaler
  assign src_en    = clkr.source ? 1'b1 : (xtal_s2 & ~xtal_s3);
  assign conv_tick = src_en & (div_cnt >= prescale_limit(clkr.prescale));

  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      div_cnt <= 4'h0;
    else if (conv_tick)
      div_cnt <= 4'h0;
    else if (src_en)
      div_cnt <= div_cnt + 4'h1;
  end

  // ==========================================================================
  // conversion sequencer
  assign powered  = (ctrl.chan != sadc_pkg::CHAN_OFF);
  assign halt     = STOP_MODE_IN | ~powered;
  assign conv_end = ~halt & ~wr_status & conv_tick & (state == sadc_pkg::ST_CONVERT)
                    & (step == sadc_pkg::STEP_LAST);
  assign bit_idx  = sadc_pkg::BIT_TOP - step[3:1];

  // set trial bit on even step, keep or drop it on odd step
  always_comb
  begin
    next_trial = trial;
    if (!step[0])
      next_trial[bit_idx] = 1'b1;
    else if (!cmp_s2)
      next_trial[bit_idx] = 1'b0;
  end

  // pending request survives stop so work resumes afterwards
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      run_req <= 1'b0;
    else if (wr_status)
      run_req <= (w_data[4:0] != sadc_pkg::CHAN_OFF);
    else if (~powered | (conv_end & ~ctrl.cont))
      run_req <= 1'b0;
  end

  // settling period owed after power-off or stop
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      need_settle <= 1'b1;
    else if (halt)
      need_settle <= 1'b1;
    else if (conv_tick & (state == sadc_pkg::ST_SETTLE) & (step == sadc_pkg::STEP_LAST))
      need_settle <= 1'b0;
  end

  // step machine, one step per converter clock; a status write restarts from idle so
  // the run spans 16 to 17 converter clocks
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      state <= sadc_pkg::ST_IDLE;
      step  <= 4'h0;
      trial <= 8'h00;
    end
    else if (halt)
    begin
      state <= sadc_pkg::ST_IDLE;
      step  <= 4'h0;
      trial <= 8'h00;
    end
    else if (wr_status)
    begin
      state <= sadc_pkg::ST_IDLE;
      step  <= 4'h0;
      trial <= 8'h00;
    end
    else if (conv_tick)
    begin
      unique case (state)
        sadc_pkg::ST_IDLE:
          if (run_req)
            state <= need_settle ? sadc_pkg::ST_SETTLE : sadc_pkg::ST_CONVERT;
        sadc_pkg::ST_SETTLE:
        begin
          step <= step + 4'h1;
          if (step == sadc_pkg::STEP_LAST)
            state <= sadc_pkg::ST_CONVERT;
        end
        sadc_pkg::ST_CONVERT:
        begin
          step  <= step + 4'h1;
          trial <= (step == sadc_pkg::STEP_LAST) ? 8'h00 : next_trial;
          if (step == sadc_pkg::STEP_LAST && !ctrl.cont)
            state <= sadc_pkg::ST_IDLE;
        end
        default:
          state <= sadc_pkg::ST_IDLE;
      endcase
    end
  end

  // result register rewritten at every conversion end
  always_ff @(posedge MCLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      result <= 8'h00;
    else if (conv_end)
      result <= next_trial;
  end

  assign CHANNEL_SEL_OUT = ctrl.chan;
  assign TRIAL_CODE_OUT  = trial;

  // ==========================================================================
  // checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);

  AST_DONE_MASKED: assert property (ctrl.irq_en |=> !(ctrl.done & ctrl.irq_en))
    else $error("done flag set while interrupt enabled");
  AST_DONE_SET: assert property (conv_end && !ctrl.irq_en |=> ctrl.done)
    else $error("done flag not set at conversion end");
  AST_DONE_HOLD: assert property (
    ctrl.done && !rd_result && !wr_status && !ctrl.irq_en |=> ctrl.done)
    else $error("done flag dropped without clear");
  AST_IRQ_SET: assert property (conv_end && ctrl.irq_en |=> IRQ_OUT ##0 !ctrl.done)
    else $error("interrupt missing at conversion end");
  AST_IRQ_DROP: assert property ((rd_result || wr_status) && !conv_end |=> !IRQ_OUT)
    else $error("interrupt not dropped");
  AST_RESULT: assert property (conv_end |=> result == $past(next_trial))
    else $error("result not updated");
  AST_STOP_ABORT: assert property (STOP_MODE_IN |=> state == sadc_pkg::ST_IDLE)
    else $error("conversion not aborted in stop");
  AST_POWER_OFF: assert property (
    POWER_DOWN_OUT |-> state == sadc_pkg::ST_IDLE && !IRQ_OUT && !run_req)
    else $error("converter active while powered off");
  AST_ONESHOT: assert property (
    conv_end && !ctrl.cont |=> state == sadc_pkg::ST_IDLE && !run_req)
    else $error("single conversion repeated");
  AST_START: assert property (
    wr_status && w_data[4:0] != sadc_pkg::CHAN_OFF
    |=> state == sadc_pkg::ST_IDLE && run_req && step == 4'h0)
    else $error("status write did not arm a conversion");
  AST_LEAVE_IDLE: assert property (
    state == sadc_pkg::ST_IDLE && run_req && conv_tick && !halt && !wr_status
    |=> state != sadc_pkg::ST_IDLE)
    else $error("armed conversion did not begin");
  AST_SETTLE: assert property ($fell(POWER_DOWN_OUT) |-> need_settle)
    else $error("settling period skipped");

  COV_SINGLE: cover property (conv_end && !ctrl.cont && !ctrl.irq_en);
  COV_CONT: cover property (conv_end && ctrl.cont ##1 state == sadc_pkg::ST_CONVERT);
  COV_IRQ: cover property (IRQ_OUT ##1 rd_result);
  COV_STOP: cover property (state == sadc_pkg::ST_CONVERT ##1 STOP_MODE_IN);

endmodule

/* verif/sadc_analog_model.sv */
`timescale 1ns/10ps

// ==========================================
// analog input multiplexer and comparator
module sadc_analog_model (
  input  wire logic         clk_in,
  input  wire logic [119:0] levels_in,
  input  wire logic         slow_in,
  input  wire logic [4:0]   chan_in,
  input  wire logic [7:0]   trial_in,
  input  wire logic         power_down_in,
  output logic              compare_out
);
  logic [7:0] picked;
  logic       raw;
  logic       held = 1'b0;
  logic       noise = 1'b0;

  // mux: external inputs, internal references, garbage elsewhere
  always_comb
  begin
    if (chan_in <= 5'h0e)
      picked = levels_in[chan_in*8 +: 8];
    else if (chan_in == sadc_pkg::CHAN_HREF)
      picked = 8'hff;
    else if (chan_in == sadc_pkg::CHAN_LREF)
      picked = 8'h00;
    else
      picked = {trial_in[3:0], 4'h5};
    raw = (picked >= trial_in);
  end

  // slow comparator lags one cycle; powered-off output wanders
  always_ff @(posedge clk_in)
  begin
    noise <= ~noise;
    held  <= raw;
  end

  assign compare_out = power_down_in ? noise : (slow_in ? held : raw);
endmodule

/* verif/sar_adc_control_bench.sv */
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module sar_adc_control_bench;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   awaddr = 8'h00;
  logic         awvalid = 1'b0;
  logic [31:0]  wdata = 32'h0;
  logic [3:0]   wstrb = 4'hf;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic [7:0]   araddr = 8'h00;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic         xclk = 1'b0;
  logic         stop = 1'b0;
  logic         slow = 1'b0;
  logic [119:0] levels = '0;
  logic         awready, wready, bvalid, arready, rvalid, pdown, irq, cmp;
  logic [1:0]   bresp, rresp, rsp;
  logic [31:0]  rdata, rd;
  logic [4:0]   chsel, ch;
  logic [7:0]   trial;
  int           seed = 32'h7204db18;
  int           failures = 0;
  int           comparisons = 0;
  int           n;
  int           bad;

  // ==========================================
  // clocks: bus 20 MHz, crystal 4 MHz
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    forever #125 xclk = ~xclk;
  end

  sadc_top sadc_top_inst (.MCLK_IN(mclk), .RESET_IN(rst), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .CRYSTAL_CLK_IN(xclk), .COMPARE_IN(cmp), .STOP_MODE_IN(stop), .CHANNEL_SEL_OUT(chsel),
    .TRIAL_CODE_OUT(trial), .POWER_DOWN_OUT(pdown), .IRQ_OUT(irq));

  sadc_analog_model sadc_analog_model_inst (.clk_in(mclk), .levels_in(levels),
    .slow_in(slow), .chan_in(chsel), .trial_in(trial), .power_down_in(pdown),
    .compare_out(cmp));

  // ==========================================
  // expectations
  function automatic logic [7:0] exp_result(input logic [4:0] c);
    if (c == sadc_pkg::CHAN_HREF)
      return 8'hff;
    if (c == sadc_pkg::CHAN_LREF)
      return 8'h00;
    return levels[c*8 +: 8];
  endfunction

  function automatic int exp_div(input logic [2:0] p);
    return p[2] ? 16 : (1 << p[1:0]);
  endfunction

  // ==========================================
  // register bus master
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int k;
    k = 0;
    r = 2'h3;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (k == 0)
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        k = 1;
      end
    end
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    r = 2'h3;
    d = 32'hffffffff;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (k == 0)
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        k = 1;
      end
    end
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  // poll the done flag, bounded
  task automatic poll_done;
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && k < 300)
    begin
      axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
      k++;
    end
    `CHK(rd[7], 1'b1)
  endtask

  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 1; i < 14; i++)
      levels[i*8 +: 8] <= 8'($random(seed));
    levels[119:112] <= 8'hff;
    @(posedge mclk);
    `CHK({chsel, pdown, irq}, 7'h7e)
    axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
    `CHK(rd, 32'h0000001f)
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, 32'h00000000)
    axi_read(sadc_pkg::OFS_CLOCK, rd, rsp);
    `CHK(rd, 32'h00000000)
    axi_read(8'h0c, rd, rsp);
    `CHK({rsp, rd}, {sadc_pkg::RESP_SLV, 32'h0})
    axi_write(sadc_pkg::OFS_RESULT, 8'h55, rsp);
    `CHK(rsp, sadc_pkg::RESP_SLV)
    $display("reset and map test done");
    // bus source, divide by 16 for 1.25 MHz, reserved bits ignored
    axi_write(sadc_pkg::OFS_CLOCK, 8'h9f, rsp);
    axi_read(sadc_pkg::OFS_CLOCK, rd, rsp);
    `CHK(rd, 32'h00000090)
    for (int k = 0; k < 18; k++)
    begin
      ch = (k < 15) ? 5'(k) : (k == 15) ? sadc_pkg::CHAN_HREF : (k == 16) ? 5'h1b
         : sadc_pkg::CHAN_LREF;
      slow <= 1'($random(seed));
      axi_write(sadc_pkg::OFS_STATUS, {3'b000, ch}, rsp);
      `CHK({chsel, pdown}, {ch, 1'b0})
      poll_done();
      axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
      if (ch != 5'h1b)
        `CHK(rd, {24'h0, exp_result(ch)})
      axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
      `CHK(rd, {24'h0, 3'b000, ch})
    end
    slow <= 1'b0;
    wstrb <= 4'he;
    axi_write(sadc_pkg::OFS_STATUS, 8'h05, rsp);
    wstrb <= 4'hf;
    axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
    `CHK({rsp, rd}, {sadc_pkg::RESP_OKAY, 32'h1e})
    $display("channel sweep test done");
    // every prescale code, bus source, interrupt mode
    for (int p = 0; p < 8; p++)
    begin
      axi_write(sadc_pkg::OFS_CLOCK, {3'(p), 5'h10}, rsp);
      axi_write(sadc_pkg::OFS_STATUS, 8'h45, rsp);
      `CHK(irq, 1'b0)
      wait_irq();
      `CHK(n >= 16*exp_div(3'(p))-3 && n <= 17*exp_div(3'(p))+1, 1'b1)
      axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
      `CHK(rd, 32'h00000045)
      axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
      `CHK(irq, 1'b0)
    end
    axi_write(sadc_pkg::OFS_CLOCK, 8'h90, rsp);
    axi_write(sadc_pkg::OFS_STATUS, 8'h45, rsp);
    wait_irq();
    axi_write(sadc_pkg::OFS_STATUS, 8'h45, rsp);
    `CHK(irq, 1'b0)
    wait_irq();
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, {24'h0, exp_result(5'h05)})
    $display("prescale and interrupt test done");
    // continuous mode picks up a new level, then single mode stops
    axi_write(sadc_pkg::OFS_STATUS, 8'h23, rsp);
    poll_done();
    levels[31:24] <= 8'($random(seed));
    repeat (2)
    begin
      axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
      poll_done();
    end
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, {24'h0, exp_result(5'h03)})
    axi_write(sadc_pkg::OFS_STATUS, 8'h03, rsp);
    poll_done();
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    repeat (300) @(posedge mclk);
    axi_read(sadc_pkg::OFS_STATUS, rd, rsp);
    `CHK(rd, 32'h00000003)
    $display("continuous test done");
    // power off with interrupt enabled: nothing happens; recovery settles
    axi_write(sadc_pkg::OFS_STATUS, 8'h5f, rsp);
    bad = 0;
    repeat (300)
    begin
      @(posedge mclk);
      bad += (irq !== 1'b0 || pdown !== 1'b1) ? 1 : 0;
    end
    `CHK(bad, 0)
    axi_write(sadc_pkg::OFS_STATUS, 8'h45, rsp);
    wait_irq();
    `CHK(n >= 32*16-3 && n <= 33*16+1, 1'b1)
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, {24'h0, exp_result(5'h05)})
    $display("power off test done");
    // stop in mid-conversion aborts; work resumes with settling after stop
    axi_write(sadc_pkg::OFS_STATUS, 8'h45, rsp);
    repeat (40) @(posedge mclk);
    stop <= 1'b1;
    repeat (3) @(posedge mclk);
    bad = 0;
    repeat (100)
    begin
      @(posedge mclk);
      bad += (irq !== 1'b0 || trial !== 8'h00) ? 1 : 0;
    end
    `CHK(bad, 0)
    stop <= 1'b0;
    wait_irq();
    `CHK(n >= 31*16 && n <= 34*16+2, 1'b1)
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, {24'h0, exp_result(5'h05)})
    $display("stop test done");
    // crystal source, divide by four for 1 MHz
    axi_write(sadc_pkg::OFS_CLOCK, 8'h40, rsp);
    axi_write(sadc_pkg::OFS_STATUS, 8'h48, rsp);
    wait_irq();
    `CHK(n >= 16*20-6 && n <= 17*20+6, 1'b1)
    axi_read(sadc_pkg::OFS_RESULT, rd, rsp);
    `CHK(rd, {24'h0, exp_result(5'h08)})
    $display("crystal source test done");
    wrap_up();
  end
endmodule
